//--- include/bidir_fifo_pkg.sv
// shared constants for the bidirectional clocked buffer
package bidir_fifo_pkg;

  // ****************************************
  // data path
  // ****************************************
  localparam int DATA_W = 36;
  localparam int QUEUE_DEPTH = 512;
  localparam int OFFS_W = 9;

  // ****************************************
  // offset presets, chosen by the two selects
  // ****************************************
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_LH = 2'h1;
  localparam logic [1:0] SEL_HL = 2'h2;
  localparam logic [1:0] SEL_HH = 2'h3;
  localparam logic [8:0] PRESET_LH = 9'h008;
  localparam logic [8:0] PRESET_HL = 9'h010;
  localparam logic [8:0] PRESET_HH = 9'h040;
  localparam logic [8:0] OFFS_RESET = 9'h008;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int WB_AW = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_OFFS_A = 8'h08;
  localparam logic [7:0] ADR_OFFS_B = 8'h0c;
  localparam int CTRL_A_OFF = 0;
  localparam int CTRL_B_OFF = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STATUS_W = 11;

  // ****************************************
  // offset programming order
  // ****************************************
  typedef enum logic [1:0] {
    PROG_AF_A = 2'b00,
    PROG_AE_B = 2'b01,
    PROG_AF_B = 2'b10,
    PROG_AE_A = 2'b11
  } prog_e;

endpackage : bidir_fifo_pkg

//--- rtl/queue_lane.sv
// one direction of the buffer: storage, pointers and ready flags
`timescale 1ns/100ps
module queue_lane
  import bidir_fifo_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = QUEUE_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic queueRst,
  // write side
  input wire logic wrTick,
  input wire logic wrReq,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic holdInput,
  output logic inReady,
  output logic [$clog2(DEPTH):0] wrCount,
  // read side
  input wire logic rdTick,
  input wire logic rdReq,
  output logic outReady,
  output logic [WIDTH-1:0] outWord,
  output logic [$clog2(DEPTH):0] rdCount
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic [AW:0] wSync1;
  logic [AW:0] wSync2;
  logic [AW:0] rSync1;
  logic [AW:0] rSync2;
  logic wake;

  wire doWrite = wrTick & wrReq & inReady;
  wire [AW:0] nextWrPtr = wrPtr + {{AW{1'b0}}, doWrite};
  wire [AW:0] nextFill = nextWrPtr - rSync2;
  wire haveWord = (wSync2 != rdPtr);
  wire doPop = rdTick & (!outReady | rdReq) & haveWord;

  assign wrCount = wrPtr - rSync2;
  assign rdCount = wSync2 - rdPtr + {{AW{1'b0}}, outReady};

  // ****
  // write side, on the writer's edges
  // ****
  always_ff @(posedge core_clk) begin
    if (sys_rst | queueRst) begin
      wrPtr <= '0;
      rSync1 <= '0;
      rSync2 <= '0;
      wake <= 1'b0;
      inReady <= 1'b0; // R06
    end else if (wrTick) begin
      rSync1 <= rdPtr; // R24
      rSync2 <= rSync1; // R24
      wrPtr <= nextWrPtr;
      wake <= 1'b1;
      // full is judged against a stale read pointer, so it errs safe
      inReady <= wake & !holdInput & (nextFill != (AW + 1)'(DEPTH)); // R05 R06
    end
  end

  // storage has no reset: contents are dont-care until written
  always_ff @(posedge core_clk) begin
    if (doWrite) begin // R05
      mem[wrPtr[AW-1:0]] <= wrData;
    end
  end

  // ****
  // read side, on the reader's edges
  // ****
  always_ff @(posedge core_clk) begin
    if (sys_rst | queueRst) begin
      rdPtr <= '0;
      wSync1 <= '0;
      wSync2 <= '0;
      outReady <= 1'b0; // R14
      outWord <= '0;
    end else if (rdTick) begin
      wSync1 <= wrPtr; // R24
      wSync2 <= wSync1; // R24
      if (doPop) begin
        outWord <= mem[rdPtr[AW-1:0]]; // R14
        rdPtr <= rdPtr + 1'b1;
        outReady <= 1'b1; // R13
      end else if (rdReq) begin
        outReady <= 1'b0; // R13
      end
    end
  end

endmodule : queue_lane

//--- rtl/bidir_clocked_fifo_port_ctrl.sv
// port control, flags and mailboxes of a two-port bidirectional buffer
//
// Behaviour
// R01 - chip select low gates edges; high floats data
// R02 - enable high needed for any port edge
// R03 - reset rise latches selects, applies preset offsets
// R04 - joint reset, selects low: four offset writes
// R05 - input-ready low means full, blocks writes
// R06 - input-ready low in reset, high second edge
// R07 - mailbox select steers access to mailbox
// R08 - output mux: mailbox or queue output register
// R09 - mailbox write drives its flag low
// R10 - no mailbox write while its flag low
// R11 - mailbox read on far port raises flag
// R12 - queue reset forces its mailbox flag high
// R13 - output-ready low means empty, blocks reads
// R14 - output-ready low in reset, high third edge
// R15 - host holds reset over four edges each
// R16 - each reset release latches its offset pair
// R17 - host resets each queue before first write
// R18 - port A: high writes, low reads, drives
// R19 - port B: low writes, high reads, drives
// R20 - almost-empty low at count within offset
// R21 - almost-full low at free within offset
// R22 - offsets load in fixed four-step order
// R23 - host gives offsets 1..508 on low bits
// R24 - pointers cross port domains through two stages
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module bidir_clocked_fifo_port_ctrl
  import bidir_fifo_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  // system
  input wire logic core_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // queue resets and offset selects
  input wire logic a_to_b_queue_reset_n,
  input wire logic b_to_a_queue_reset_n,
  input wire logic offset_select_lo,
  input wire logic offset_select_hi,
  // port A control
  input wire logic porta_clock,
  input wire logic porta_select_n,
  input wire logic porta_enable,
  input wire logic porta_write_not_read,
  input wire logic porta_mailbox_select,
  // port A data
  input wire logic [DATA_W-1:0] porta_data_in,
  output logic [DATA_W-1:0] porta_data_out,
  output logic porta_data_oe,
  // port A flags
  output logic porta_input_ready,
  output logic porta_output_ready,
  output logic porta_almost_empty_n,
  output logic porta_almost_full_n,
  // port B control
  input wire logic portb_clock,
  input wire logic portb_select_n,
  input wire logic portb_enable,
  input wire logic portb_read_not_write,
  input wire logic portb_mailbox_select,
  // port B data
  input wire logic [DATA_W-1:0] portb_data_in,
  output logic [DATA_W-1:0] portb_data_out,
  output logic portb_data_oe,
  // port B flags
  output logic portb_input_ready,
  output logic portb_output_ready,
  output logic portb_almost_empty_n,
  output logic portb_almost_full_n,
  // mailbox flags
  output logic a_to_b_mail_flag_n,
  output logic b_to_a_mail_flag_n
);
  localparam int CW = $clog2(DEPTH) + 1;

  // ****
  // port clock edges
  // ****
  // port clocks are sampled as plain inputs; each rising edge becomes
  // a one-cycle enable, so the port clock must be well below core_clk
  logic clkAPrev;
  logic clkBPrev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkAPrev <= 1'b1; // a clock already high at release is no edge
      clkBPrev <= 1'b1;
    end else begin
      clkAPrev <= porta_clock;
      clkBPrev <= portb_clock;
    end
  end

  wire tickA = porta_clock & !clkAPrev;
  wire tickB = portb_clock & !clkBPrev;

  // ****
  // control register and per-lane arrays
  // ****
  logic [1:0] ctrl;
  logic progActive;
  prog_e progStep;

  logic [1:0] wrTick;
  logic [1:0] rdTick;
  logic [1:0] qRst;
  logic [1:0] rise;
  logic [1:0] wrReq;
  logic [1:0] rdReq;
  logic [1:0] hold;
  logic [1:0] inReady;
  logic [1:0] outReady;
  logic [1:0] mailWr;
  logic [1:0] mailRd;
  logic [1:0] mailFlagN;
  logic [1:0] loadFull;
  logic [1:0] loadEmpty;
  logic [1:0] almostFullN;
  logic [1:0] almostEmptyN;
  logic [DATA_W-1:0] wrData [2];
  logic [DATA_W-1:0] outWord [2];
  logic [DATA_W-1:0] mailWord [2];
  logic [CW-1:0] wrCnt [2];
  logic [CW-1:0] rdCnt [2];
  logic [OFFS_W-1:0] fullOff [2];
  logic [OFFS_W-1:0] emptyOff [2];

  // ****
  // port A decode
  // ****
  wire okA = tickA & !porta_select_n & porta_enable & !ctrl[CTRL_A_OFF]; // R01 R02
  wire aWrite = porta_write_not_read; // R18
  wire aWrStrobe = okA & aWrite & !porta_mailbox_select; // R07
  wire aWrQueue = aWrStrobe & !progActive; // R04
  wire aProgLoad = aWrStrobe & progActive & inReady[0]; // R04
  wire aWrMail = okA & aWrite & porta_mailbox_select; // R07
  wire aRdQueue = okA & !aWrite & !porta_mailbox_select & outReady[1]; // R13
  wire aRdMail = okA & !aWrite & porta_mailbox_select; // R07

  // ****
  // port B decode
  // ****
  wire okB = tickB & !portb_select_n & portb_enable & !ctrl[CTRL_B_OFF]; // R01 R02
  wire bWrite = !portb_read_not_write; // R19
  wire bWrQueue = okB & bWrite & !portb_mailbox_select; // R07
  wire bWrMail = okB & bWrite & portb_mailbox_select; // R07
  wire bRdQueue = okB & !bWrite & !portb_mailbox_select & outReady[0]; // R13
  wire bRdMail = okB & !bWrite & portb_mailbox_select; // R07

  // ****
  // lane wiring: lane 0 runs A to B, lane 1 runs B to A
  // ****
  assign wrTick = {tickB, tickA};
  assign rdTick = {tickA, tickB};
  assign qRst = {!b_to_a_queue_reset_n, !a_to_b_queue_reset_n};
  assign wrReq = {bWrQueue, aWrQueue};
  assign rdReq = {aRdQueue, bRdQueue};
  // the B side stays closed until programming is over
  assign hold = {progActive, 1'b0}; // R04
  assign mailWr = {bWrMail, aWrMail};
  assign mailRd = {aRdMail, bRdMail};
  assign wrData[0] = porta_data_in;
  assign wrData[1] = portb_data_in;

  // ****
  // offset programming from port A
  // ****
  wire [1:0] offsetSel = {offset_select_hi, offset_select_lo};
  wire bothRise = rise[0] & rise[1] & (offsetSel == SEL_NONE); // R04
  wire [OFFS_W-1:0] presetVal = (offsetSel == SEL_HH) ? PRESET_HH :
                                (offsetSel == SEL_HL) ? PRESET_HL : PRESET_LH;
  wire [OFFS_W-1:0] progVal = porta_data_in[OFFS_W-1:0]; // R23

  assign loadFull[0] = aProgLoad & (progStep == PROG_AF_A); // R22
  assign loadEmpty[0] = aProgLoad & (progStep == PROG_AE_B); // R22
  assign loadFull[1] = aProgLoad & (progStep == PROG_AF_B); // R22
  assign loadEmpty[1] = aProgLoad & (progStep == PROG_AE_A); // R22

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      progActive <= 1'b0;
      progStep <= PROG_AF_A;
    end else if (bothRise) begin
      progActive <= 1'b1; // R04
      progStep <= PROG_AF_A;
    end else if (aProgLoad) begin
      case (progStep)
        PROG_AF_A: progStep <= PROG_AE_B; // R22
        PROG_AE_B: progStep <= PROG_AF_B; // R22
        PROG_AF_B: progStep <= PROG_AE_A; // R22
        PROG_AE_A: progActive <= 1'b0; // R22
        default: progStep <= PROG_AF_A;
      endcase
    end
  end

  // ****
  // per-lane logic
  // ****
  for (genvar d = 0; d < 2; d++) begin : g_lane
    logic rstPrev;
    logic [OFFS_W-1:0] fullOffR;
    logic [OFFS_W-1:0] emptyOffR;
    logic afN;
    logic aeN;
    logic mbN;
    logic [DATA_W-1:0] mbWord;
    wire [CW-1:0] freeCnt = CW'(DEPTH) - wrCnt[d];

    queue_lane #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH)
    ) u_lane (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .queueRst(qRst[d]),
      .wrTick(wrTick[d]),
      .wrReq(wrReq[d]),
      .wrData(wrData[d]),
      .holdInput(hold[d]),
      .inReady(inReady[d]),
      .wrCount(wrCnt[d]),
      .rdTick(rdTick[d]),
      .rdReq(rdReq[d]),
      .outReady(outReady[d]),
      .outWord(outWord[d]),
      .rdCount(rdCnt[d])
    );

    // reset release seen as a low-to-high step of the reset line
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        rstPrev <= 1'b0;
      end else begin
        rstPrev <= qRst[d];
      end
    end
    assign rise[d] = rstPrev & !qRst[d];

    // offset pair of this lane: writer's full, reader's empty
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        fullOffR <= OFFS_RESET;
        emptyOffR <= OFFS_RESET;
      end else if (rise[d] && offsetSel != SEL_NONE) begin
        fullOffR <= presetVal; // R03 R16
        emptyOffR <= presetVal; // R03 R16
      end else begin
        if (loadFull[d]) begin
          fullOffR <= progVal; // R04
        end
        if (loadEmpty[d]) begin
          emptyOffR <= progVal; // R04
        end
      end
    end
    assign fullOff[d] = fullOffR;
    assign emptyOff[d] = emptyOffR;

    // almost flags, each on its own port's edges
    always_ff @(posedge core_clk) begin
      if (sys_rst | qRst[d]) begin
        afN <= 1'b1;
      end else if (wrTick[d]) begin
        afN <= !(freeCnt <= CW'(fullOffR)); // R21
      end
    end
    always_ff @(posedge core_clk) begin
      if (sys_rst | qRst[d]) begin
        aeN <= 1'b0;
      end else if (rdTick[d]) begin
        aeN <= !(rdCnt[d] <= CW'(emptyOffR)); // R20
      end
    end
    assign almostFullN[d] = afN;
    assign almostEmptyN[d] = aeN;

    // mailbox: a write to an empty mailbox wins over a read in the same cycle
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        mbN <= 1'b1;
        mbWord <= '0;
      end else if (qRst[d]) begin
        mbN <= 1'b1; // R12
      end else if (mailWr[d] && mbN) begin // R10
        mbWord <= wrData[d];
        mbN <= 1'b0; // R09
      end else if (mailRd[d]) begin
        mbN <= 1'b1; // R11
      end
    end
    assign mailFlagN[d] = mbN;
    assign mailWord[d] = mbWord;
  end

  // ****
  // port data outputs
  // ****
  // one core cycle behind the selects: the port clock is far slower
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      porta_data_out <= '0;
      portb_data_out <= '0;
    end else begin
      porta_data_out <= porta_mailbox_select ? mailWord[1] : outWord[1]; // R08
      portb_data_out <= portb_mailbox_select ? mailWord[0] : outWord[0]; // R08
    end
  end

  assign porta_data_oe = !porta_select_n & !porta_write_not_read; // R01 R18
  assign portb_data_oe = !portb_select_n & portb_read_not_write; // R01 R19

  // ****
  // flag outputs
  // ****
  assign porta_input_ready = inReady[0];
  assign portb_input_ready = inReady[1];
  assign porta_output_ready = outReady[1];
  assign portb_output_ready = outReady[0];
  assign porta_almost_full_n = almostFullN[0];
  assign portb_almost_full_n = almostFullN[1];
  assign portb_almost_empty_n = almostEmptyN[0];
  assign porta_almost_empty_n = almostEmptyN[1];
  assign a_to_b_mail_flag_n = mailFlagN[0];
  assign b_to_a_mail_flag_n = mailFlagN[1];

  // ****
  // register bus slave
  // ****
  wire [STATUS_W-1:0] status = {
    progActive, mailFlagN[1], mailFlagN[0],
    almostFullN[1], almostEmptyN[0], outReady[0], inReady[1],
    almostFullN[0], almostEmptyN[1], outReady[1], inReady[0]
  };
  wire wbReq = wb_cyc_i & wb_stb_i;
  wire wbCommit = wbReq & wb_we_i & wb_ack_o;
  wire hitCtrl = (wb_adr_i == ADR_CTRL);
  wire hitStatus = (wb_adr_i == ADR_STATUS);
  wire hitOffsA = (wb_adr_i == ADR_OFFS_A);
  wire hitOffsB = (wb_adr_i == ADR_OFFS_B);
  // unmapped addresses are acknowledged and read as zero
  wire [31:0] rdMux =
    hitCtrl ? {30'h0, ctrl} :
    hitStatus ? {{(32 - STATUS_W){1'b0}}, status} :
    hitOffsA ? {7'h00, emptyOff[1], 7'h00, fullOff[0]} :
    hitOffsB ? {7'h00, emptyOff[0], 7'h00, fullOff[1]} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbReq & !wb_ack_o;
      if (wbReq && !wb_ack_o) begin
        wb_dat_o <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (wbCommit && hitCtrl && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

endmodule : bidir_clocked_fifo_port_ctrl

//--- dv/bidir_fifo_checker_sva.sv
// concurrent checks on the port control and flag outputs
`timescale 1ns/100ps
module bidir_fifo_checker
  import bidir_fifo_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  // system
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic a_to_b_queue_reset_n,
  // port A
  input wire logic porta_clock,
  input wire logic porta_select_n,
  input wire logic porta_enable,
  input wire logic porta_write_not_read,
  input wire logic porta_mailbox_select,
  input wire logic porta_data_oe,
  input wire logic porta_input_ready,
  input wire logic porta_almost_full_n,
  // port B
  input wire logic portb_clock,
  input wire logic portb_select_n,
  input wire logic portb_enable,
  input wire logic portb_read_not_write,
  input wire logic portb_mailbox_select,
  input wire logic portb_data_oe,
  input wire logic portb_output_ready,
  input wire logic portb_almost_empty_n,
  input wire logic a_to_b_mail_flag_n
);
  // ****
  // tick detection
  // ****
  logic prevA;
  logic prevB;
  always_ff @(posedge core_clk) begin
    prevA <= porta_clock;
    prevB <= portb_clock;
  end
  // port clocks are sampled as data, so a tick is a newly seen high level
  wire aTick = porta_clock && !prevA;
  wire bTick = portb_clock && !prevB;
  wire aMailWr = aTick && !porta_select_n && porta_enable && porta_write_not_read
    && porta_mailbox_select;
  wire bMailRd = bTick && !portb_select_n && portb_enable && portb_read_not_write
    && portb_mailbox_select;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_oe_a;
    porta_data_oe == (!porta_select_n && !porta_write_not_read);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("port A drive enable wrong");
  property p_oe_b;
    portb_data_oe == (!portb_select_n && portb_read_not_write);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port B drive enable wrong");
  property p_in_reset;
    !a_to_b_queue_reset_n [*2] |-> !porta_input_ready && !portb_output_ready
      && !portb_almost_empty_n && porta_almost_full_n && a_to_b_mail_flag_n;
  endproperty
  a_in_reset: assert property (p_in_reset) else $error("flags wrong in reset");
  property p_ir_tick;
    a_to_b_queue_reset_n && $past(a_to_b_queue_reset_n) && $changed(porta_input_ready)
      |-> $past(aTick);
  endproperty
  a_ir_tick: assert property (p_ir_tick) else $error("input ready off its clock");
  property p_or_tick;
    a_to_b_queue_reset_n && $past(a_to_b_queue_reset_n) && $changed(portb_output_ready)
      |-> $past(bTick);
  endproperty
  a_or_tick: assert property (p_or_tick) else $error("output ready off its clock");
  property p_mail_set;
    $fell(a_to_b_mail_flag_n) |-> $past(aMailWr);
  endproperty
  a_mail_set: assert property (p_mail_set) else $error("mail flag fell unasked");
  property p_mail_clear;
    $rose(a_to_b_mail_flag_n) |-> $past(bMailRd) || !$past(a_to_b_queue_reset_n);
  endproperty
  a_mail_clear: assert property (p_mail_clear) else $error("mail flag rose unasked");
  property p_mail_hold;
    !a_to_b_mail_flag_n && !bTick && a_to_b_queue_reset_n |=> !a_to_b_mail_flag_n;
  endproperty
  a_mail_hold: assert property (p_mail_hold) else $error("mail flag lost");
  property p_ignored;
    aTick && (porta_select_n || !porta_enable) && !bTick && a_to_b_queue_reset_n
      |=> $stable(a_to_b_mail_flag_n);
  endproperty
  a_ignored: assert property (p_ignored) else $error("ignored edge acted");
  c_mail: cover property ($fell(a_to_b_mail_flag_n));
  c_or: cover property ($rose(portb_output_ready));
  c_ir: cover property ($rose(porta_input_ready));
endmodule : bidir_fifo_checker

//--- dv/portb_host.sv
// host model driving port B of the buffer
`timescale 1ns/100ps
module portb_host
  import bidir_fifo_pkg::*;
(
  // system
  input wire logic core_clk,
  // port B pins
  output logic portb_clock,
  output logic portb_select_n,
  output logic portb_enable,
  output logic portb_read_not_write,
  output logic portb_mailbox_select,
  output logic [DATA_W-1:0] portb_data_in
);
  // ****
  // free-running clock, three cycles high and three low
  // ****
  logic [2:0] phase = 3'h0;
  initial begin
    portb_clock = 1'b0;
    portb_select_n = 1'b1;
    portb_enable = 1'b0;
    portb_read_not_write = 1'b1;
    portb_mailbox_select = 1'b0;
    portb_data_in = '0;
  end
  always @(posedge core_clk) begin
    phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
    portb_clock <= (phase > 3'h2);
  end
  // one access per tick; data flips after so a stale word is never reused
  task automatic op(input logic en, input logic rd, input logic mb,
                    input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    while (portb_clock !== 1'b0) @(posedge core_clk);
    portb_select_n <= 1'b0;
    portb_enable <= en;
    portb_read_not_write <= rd;
    portb_mailbox_select <= mb;
    portb_data_in <= d;
    @(posedge core_clk);
    while (portb_clock !== 1'b1) @(posedge core_clk);
    portb_enable <= 1'b0;
    portb_data_in <= ~d;
    @(posedge core_clk);
  endtask : op
endmodule : portb_host

//--- dv/tb_bidir_clocked_fifo_port_ctrl.sv
// self-checking bench for the port control block
`timescale 1ns/100ps
module tb_bidir_clocked_fifo_port_ctrl
  import bidir_fifo_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [WB_AW-1:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic a_to_b_queue_reset_n, b_to_a_queue_reset_n, offset_select_lo, offset_select_hi;
  logic porta_select_n, porta_enable, porta_write_not_read, porta_mailbox_select;
  logic porta_data_oe, porta_input_ready, porta_output_ready;
  logic porta_almost_empty_n, porta_almost_full_n;
  logic portb_clock, portb_select_n, portb_enable, portb_read_not_write, portb_mailbox_select;
  logic portb_data_oe, portb_input_ready, portb_output_ready;
  logic portb_almost_empty_n, portb_almost_full_n, a_to_b_mail_flag_n, b_to_a_mail_flag_n;
  logic [DATA_W-1:0] porta_data_in, porta_data_out, portb_data_in, portb_data_out;
  logic [DATA_W-1:0] word = 36'h987654321;
  logic [DATA_W-1:0] mailA = 36'h123456789;
  logic [DATA_W-1:0] mailB = 36'habcdef012;
  logic [8:0] offs [4] = '{9'h005, 9'h006, 9'h1fc, 9'h001};
  wire [9:0] resetFlags = {porta_input_ready, portb_output_ready, portb_almost_empty_n,
    porta_almost_full_n, a_to_b_mail_flag_n, b_to_a_mail_flag_n, porta_output_ready,
    porta_almost_empty_n, portb_almost_full_n, portb_input_ready};
  wire [2:0] readyNow = {portb_input_ready, portb_output_ready, porta_input_ready};
  int failCount = 0;
  int testsRun = 0;
  int cycles = 0;
  int n;
  logic [1:0] phaseA = 2'h0;
  logic porta_clock = 1'b0;
  logic [1:0] clkSeen = 2'h0;
  bidir_clocked_fifo_port_ctrl bidir_clocked_fifo_port_ctrl_i (.*);
  portb_host portb_host_i (.*);
  // ****
  // clocks and watchdog
  // ****
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    phaseA <= phaseA + 2'h1;
    porta_clock <= phaseA[1];
    clkSeen <= {portb_clock, porta_clock};
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      summarize();
    end
  end
  // ****
  // tasks
  // ****
  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    dat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wbXfer
  task automatic aOp(input logic cs, input logic en, input logic wr, input logic mb,
                     input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    while (porta_clock !== 1'b0) @(posedge core_clk);
    porta_select_n <= cs;
    porta_enable <= en;
    porta_write_not_read <= wr;
    porta_mailbox_select <= mb;
    porta_data_in <= d;
    @(posedge core_clk);
    while (porta_clock !== 1'b1) @(posedge core_clk);
    porta_enable <= 1'b0;
    porta_data_in <= ~d;
    @(posedge core_clk);
  endtask : aOp
  // counts port ticks from this edge on, until a ready flag shows high
  task automatic tickCount(input int which, output int cnt);
    logic pc;
    logic c;
    pc = clkSeen[which != 0];
    cnt = 0;
    repeat (300) begin
      c = (which == 0) ? porta_clock : portb_clock;
      if (c && !pc) cnt++;
      pc = c;
      @(posedge core_clk);
      if (readyNow[which] === 1'b1) return;
    end
  endtask : tickCount
  task automatic summarize;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // ****
  // scenarios
  // ****
  initial begin
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {a_to_b_queue_reset_n, b_to_a_queue_reset_n, offset_select_lo, offset_select_hi} = 4'h0;
    {porta_select_n, porta_enable, porta_write_not_read, porta_mailbox_select} = 4'ha;
    porta_data_in = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge core_clk);
    check(resetFlags, 36'h072, "reset flags");
    wbXfer(1'b0, 8'h10, 32'h0, rd);
    check(rd, 36'h0, "unmapped");
    a_to_b_queue_reset_n <= 1'b1;
    b_to_a_queue_reset_n <= 1'b1;
    @(posedge core_clk);
    tickCount(0, n);
    check(n, 36'h2, "ir delay");
    foreach (offs[i]) aOp(1'b0, 1'b1, 1'b1, 1'b0, {27'h0, offs[i]});
    wbXfer(1'b0, ADR_OFFS_A, 32'h0, rd);
    check(rd, {7'h0, offs[3], 7'h0, offs[0]}, "offs a");
    wbXfer(1'b0, ADR_OFFS_B, 32'h0, rd);
    check(rd, {7'h0, offs[1], 7'h0, offs[2]}, "offs b");
    tickCount(2, n);
    check({portb_input_ready, portb_output_ready}, 36'h2, "prog done");
    wbXfer(1'b1, ADR_CTRL, 32'h1, rd);
    aOp(1'b0, 1'b1, 1'b1, 1'b0, word);
    wbXfer(1'b1, ADR_CTRL, 32'h0, rd);
    aOp(1'b1, 1'b1, 1'b1, 1'b0, word);
    aOp(1'b0, 1'b0, 1'b1, 1'b0, word);
    repeat (40) @(posedge core_clk);
    check(portb_output_ready, 36'h0, "refused writes");
    aOp(1'b0, 1'b1, 1'b1, 1'b0, word);
    tickCount(1, n);
    check(n, 36'h3, "or delay");
    portb_host_i.op(1'b0, 1'b1, 1'b0, '0);
    check(portb_data_out, word, "queue word");
    check({portb_almost_empty_n, porta_almost_full_n}, 36'h1, "almost flags");
    portb_host_i.op(1'b1, 1'b1, 1'b0, '0);
    check(portb_output_ready, 36'h0, "drained");
    aOp(1'b0, 1'b1, 1'b1, 1'b1, mailA);
    check(a_to_b_mail_flag_n, 36'h0, "mail set");
    aOp(1'b0, 1'b1, 1'b1, 1'b1, ~mailA);
    portb_host_i.op(1'b0, 1'b1, 1'b1, '0);
    check(portb_data_out, mailA, "mail held");
    portb_host_i.op(1'b1, 1'b1, 1'b1, '0);
    check(a_to_b_mail_flag_n, 36'h1, "mail taken");
    portb_host_i.op(1'b1, 1'b0, 1'b1, mailB);
    check(b_to_a_mail_flag_n, 36'h0, "mail b set");
    aOp(1'b0, 1'b0, 1'b0, 1'b1, '0);
    check(porta_data_out, mailB, "mail b seen");
    a_to_b_queue_reset_n <= 1'b0;
    b_to_a_queue_reset_n <= 1'b0;
    {offset_select_hi, offset_select_lo} <= 2'h3;
    repeat (30) @(posedge core_clk);
    check(b_to_a_mail_flag_n, 36'h1, "mail cleared");
    a_to_b_queue_reset_n <= 1'b1;
    @(posedge core_clk);
    offset_select_lo <= 1'b0;
    repeat (3) @(posedge core_clk);
    b_to_a_queue_reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    wbXfer(1'b0, ADR_OFFS_A, 32'h0, rd);
    check(rd, {7'h0, PRESET_HL, 7'h0, PRESET_HH}, "preset a");
    wbXfer(1'b0, ADR_OFFS_B, 32'h0, rd);
    check(rd, {7'h0, PRESET_HH, 7'h0, PRESET_HL}, "preset b");
    summarize();
  end
endmodule : tb_bidir_clocked_fifo_port_ctrl
bind bidir_clocked_fifo_port_ctrl bidir_fifo_checker #(.DEPTH(DEPTH)) bidir_fifo_checker_i (.*);
